// ### rtl/podc_top.sv
`timescale 1ns/1ps
`include "podc_consts.svh"

module podc_top #(
    parameter int N_IN   = 4,
    parameter int N_PAIR = 3
) (
    input  wire logic                CORE_CLK,
    input  wire logic                RSTN,
    input  wire logic [N_IN-1:0]     FAULT_REQUEST_INPUT_N,
    input  wire logic                CHANNEL0_FAULT_REQUEST_INPUT_N,
    input  wire logic [2*N_IN+1:0]   INPUT_DETECT_MODE,
    input  wire logic [N_IN:0]       INPUT_FLAG_READ,
    input  wire logic [N_IN:0]       INPUT_FLAG_CLEAR,
    output logic      [N_IN:0]       INPUT_REQUEST_FLAG,
    input  wire logic                INPUT_IRQ_EN,
    input  wire logic                CH0_IRQ_EN,
    input  wire logic [N_PAIR-1:0]   OUT_P,
    input  wire logic [N_PAIR-1:0]   OUT_N,
    input  wire logic [N_PAIR-1:0]   PIN_FUNC_OUTPUT,
    input  wire logic [N_PAIR-1:0]   OUT_CMP_EN,
    input  wire logic                ACTIVE_LEVEL_POLARITY_SELECT,
    input  wire logic                OUTPUT_LEVEL_SOURCE_SELECT,
    input  wire logic [2*N_PAIR-1:0] PIN_LEVEL_SELECT,
    input  wire logic                OUT_FLAG_READ,
    input  wire logic                OUT_FLAG_CLEAR,
    output logic                     OUTPUT_COMPARE_FLAG,
    input  wire logic                OUT_IRQ_EN,
    input  wire logic                SW_HIZ_REQ,
    output logic                     HIZ_HIGH_CURRENT,
    output logic                     HIZ_CH0,
    output logic                     IRQ_INPUT,
    output logic                     IRQ_OUTPUT
);
    logic [`PODC_PRE_W-1:0] pre_reg;
    logic                   tick8;
    logic                   tick16;
    logic                   tick128;
    logic [N_IN:0]          pins_n;
    logic [N_IN:0]          flags;
    logic [N_PAIR-1:0]      pair_hit;
    logic                   cmp_hit;
    logic                   out_flag_reg;
    logic                   out_rd_seen_reg;
    logic                   hiz_hc_reg;
    logic                   hiz_ch0_reg;
    logic                   irq_in_reg;
    logic                   irq_out_reg;

    // Refuse sizes the logic cannot serve
    generate
        if (N_IN < 1 || N_PAIR < 1) begin : g_bad
            $error("podc_top needs at least one input and one pair");
        end
    endgenerate

    // Free-running prescaler; one counter shares all three sample rates
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pre_reg <= `PODC_PRE_RST;
        end else begin
            pre_reg <= pre_reg + 7'h01;
        end
    end

    // One tick per divided period, aligned so /16 ticks nest in /8
    assign tick8   = ((pre_reg & `PODC_MASK8) == `PODC_MASK8);
    assign tick16  = ((pre_reg & `PODC_MASK16) == `PODC_MASK16);
    assign tick128 = (pre_reg == `PODC_MASK128);

    // Channel 0 input sits at the top index of the detector array
    assign pins_n = {CHANNEL0_FAULT_REQUEST_INPUT_N, FAULT_REQUEST_INPUT_N};

    // One detector per fault input
    generate
        for (genvar i = 0; i <= N_IN; i++) begin : g_det
            podc_detect u_det (
                .CORE_CLK   (CORE_CLK),
                .RSTN       (RSTN),
                .pin_n      (pins_n[i]),
                .mode_code  (INPUT_DETECT_MODE[2*i+1:2*i]),
                .tick8      (tick8),
                .tick16     (tick16),
                .tick128    (tick128),
                .flag_read  (INPUT_FLAG_READ[i]),
                .flag_clear (INPUT_FLAG_CLEAR[i]),
                .flag       (flags[i])
            );
        end
    endgenerate

    assign INPUT_REQUEST_FLAG = flags;

    // Per-pair coincidence of the active level on both pins
    generate
        for (genvar p = 0; p < N_PAIR; p++) begin : g_pair
            logic act_p;
            logic act_n;
            // Common polarity, or per-pin level when source select is 1
            assign act_p = OUTPUT_LEVEL_SOURCE_SELECT ?
                           PIN_LEVEL_SELECT[2*p] :
                           ACTIVE_LEVEL_POLARITY_SELECT;
            assign act_n = OUTPUT_LEVEL_SOURCE_SELECT ?
                           PIN_LEVEL_SELECT[2*p+1] :
                           ACTIVE_LEVEL_POLARITY_SELECT;
            // Other pin functions never take part
            assign pair_hit[p] = PIN_FUNC_OUTPUT[p] && OUT_CMP_EN[p]
                                 && (OUT_P[p] == act_p)
                                 && (OUT_N[p] == act_n);
        end
    endgenerate

    assign cmp_hit = |pair_hit;

    // Read-as-one history of the compare flag
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            out_rd_seen_reg <= `PODC_RST_FLAG;
        end else if (OUT_FLAG_CLEAR) begin
            out_rd_seen_reg <= 1'b0;
        end else if (OUT_FLAG_READ && out_flag_reg) begin
            out_rd_seen_reg <= 1'b1;
        end
    end

    // Sticky compare flag; a coincidence wins over a clear
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            out_flag_reg <= `PODC_RST_FLAG;
        end else if (cmp_hit) begin
            out_flag_reg <= 1'b1;
        end else if (OUT_FLAG_CLEAR && out_rd_seen_reg) begin
            out_flag_reg <= 1'b0;
        end
    end

    assign OUTPUT_COMPARE_FLAG = out_flag_reg;

    // High-Z requests; held as long as any cause stays set
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            hiz_hc_reg  <= `PODC_RST_HIZ;
            hiz_ch0_reg <= `PODC_RST_HIZ;
        end else begin
            hiz_hc_reg  <= (|flags) || out_flag_reg
                           || SW_HIZ_REQ;
            // Compare results guard only the high-current pins
            hiz_ch0_reg <= (|flags) || SW_HIZ_REQ;
        end
    end

    assign HIZ_HIGH_CURRENT = hiz_hc_reg;
    assign HIZ_CH0          = hiz_ch0_reg;

    // Interrupt requests beside the high-Z request
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            irq_in_reg  <= `PODC_RST_FLAG;
            irq_out_reg <= `PODC_RST_FLAG;
        end else begin
            irq_in_reg  <= (INPUT_IRQ_EN && (|flags[N_IN-1:0]))
                           || (CH0_IRQ_EN && flags[N_IN]);
            irq_out_reg <= OUT_IRQ_EN && out_flag_reg;
        end
    end

    assign IRQ_INPUT  = irq_in_reg;
    assign IRQ_OUTPUT = irq_out_reg;

    AST_FAULT_HIZ: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        flags[0] |=> (HIZ_HIGH_CURRENT && HIZ_CH0))
        else $error("fault flag did not force high-Z");
    AST_CH0_ONLY_FROM_INPUT: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        (!(|flags) && !SW_HIZ_REQ) |=> !HIZ_CH0)
        else $error("channel 0 high-Z without a cause");
    AST_CMP_CHAIN: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        pair_hit[0] |=> OUTPUT_COMPARE_FLAG ##1 HIZ_HIGH_CURRENT)
        else $error("coincidence did not lead to high-Z");
    AST_SW_FORCE: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        SW_HIZ_REQ |=> (HIZ_HIGH_CURRENT && HIZ_CH0))
        else $error("software request did not force high-Z");
    // Enable must still stand when the flag reaches the interrupt register
    AST_IRQ_OUT: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        (cmp_hit && OUT_IRQ_EN) ##1 OUT_IRQ_EN |=> IRQ_OUTPUT)
        else $error("compare interrupt missing");
    AST_IRQ_IN: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        (flags[0] && INPUT_IRQ_EN) |=> IRQ_INPUT)
        else $error("input interrupt missing");
    AST_LOW_ACTIVE: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        (!OUTPUT_LEVEL_SOURCE_SELECT && !ACTIVE_LEVEL_POLARITY_SELECT
         && PIN_FUNC_OUTPUT[0] && OUT_CMP_EN[0] && !OUT_P[0] && !OUT_N[0])
        |=> OUTPUT_COMPARE_FLAG)
        else $error("low active coincidence not caught");
    AST_NO_CHECK: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        (PIN_FUNC_OUTPUT == '0 && !OUTPUT_COMPARE_FLAG)
        |=> !OUTPUT_COMPARE_FLAG)
        else $error("level checked under another pin function");
    AST_OUT_CLEAR_NEEDS_READ: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        (OUTPUT_COMPARE_FLAG && !OUT_FLAG_READ) ##1 OUT_FLAG_CLEAR
        |-> ##1 ($past(out_rd_seen_reg) || OUTPUT_COMPARE_FLAG))
        else $error("compare flag cleared without a read");

    COV_FAULT: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        $rose(flags[0]) ##1 HIZ_HIGH_CURRENT);
    COV_CMP: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        $rose(OUTPUT_COMPARE_FLAG) ##1 IRQ_OUTPUT);
    COV_SW: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        SW_HIZ_REQ ##1 HIZ_CH0);
    COV_CLEAR: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        $fell(flags[0]));
endmodule

// ### rtl/podc_consts.svh
`ifndef PODC_CONSTS_SVH
`define PODC_CONSTS_SVH

// Low-level sampling: sixteen consecutive lows accept a request
`define PODC_LAST_SAMPLE 5'h0F
`define PODC_CNT_FULL    5'h10
`define PODC_CNT_RST     5'h00

// Prescaler width and tick masks for the /8, /16 and /128 sample rates
`define PODC_PRE_W       7
`define PODC_PRE_RST     7'h00
`define PODC_MASK8       7'h07
`define PODC_MASK16      7'h0F
`define PODC_MASK128     7'h7F

// Reset values of flags and forced high-impedance outputs
`define PODC_RST_FLAG    1'b0
`define PODC_RST_HIZ     1'b0
// Input pins idle high, so the edge history starts high
`define PODC_RST_PREV    1'b1

`endif

// ### rtl/podc_pkg.sv
package podc_pkg;
    // Input detect mode, in the order of its two-bit code 00..11
    typedef enum logic [1:0] {
        PODC_EDGE,
        PODC_DIV8,
        PODC_DIV16,
        PODC_DIV128
    } podc_mode_t;
endpackage

// ### rtl/podc_detect.sv
`timescale 1ns/1ps
`include "podc_consts.svh"

module podc_detect (
    input  wire logic       CORE_CLK,
    input  wire logic       RSTN,
    input  wire logic       pin_n,
    input  wire logic [1:0] mode_code,
    input  wire logic       tick8,
    input  wire logic       tick16,
    input  wire logic       tick128,
    input  wire logic       flag_read,
    input  wire logic       flag_clear,
    output logic            flag
);
    podc_pkg::podc_mode_t mode;
    logic       tick;
    logic       sampling;
    logic       edge_hit;
    logic       level_hit;
    logic       clear_ok;
    logic [4:0] count_reg;
    logic       prev_reg;
    logic       high_seen_reg;
    logic       rd_seen_reg;
    logic       flag_reg;

    // Mode decode and sample tick select
    assign mode     = podc_pkg::podc_mode_t'(mode_code);
    assign sampling = (mode != podc_pkg::PODC_EDGE);
    always_comb begin
        case (mode)
            podc_pkg::PODC_DIV8:   tick = tick8;
            podc_pkg::PODC_DIV16:  tick = tick16;
            podc_pkg::PODC_DIV128: tick = tick128;
            default:               tick = 1'b0;
        endcase
    end

    // Request detection per selected mode
    assign edge_hit  = !sampling && prev_reg && !pin_n;
    assign level_hit = sampling && tick && !pin_n
                       && (count_reg == `PODC_LAST_SAMPLE);
    // Clear needs a prior read of one; sampling also needs a high sample
    assign clear_ok  = flag_clear && rd_seen_reg
                       && (!sampling || high_seen_reg);

    // Edge history
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            prev_reg <= `PODC_RST_PREV;
        end else begin
            prev_reg <= pin_n;
        end
    end

    // Run of low samples; saturates so one run sets the flag only once
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            count_reg <= `PODC_CNT_RST;
        end else if (!sampling) begin
            count_reg <= `PODC_CNT_RST;
        end else if (tick && pin_n) begin
            count_reg <= `PODC_CNT_RST;
        end else if (tick && count_reg != `PODC_CNT_FULL) begin
            count_reg <= count_reg + 5'h01;
        end
    end

    // High level seen since the flag was raised
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            high_seen_reg <= `PODC_RST_FLAG;
        end else if (edge_hit || level_hit || clear_ok) begin
            high_seen_reg <= 1'b0;
        end else if (sampling && tick && pin_n) begin
            high_seen_reg <= 1'b1;
        end
    end

    // Read-as-one history, consumed by the next clear attempt
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rd_seen_reg <= `PODC_RST_FLAG;
        end else if (flag_clear) begin
            rd_seen_reg <= 1'b0;
        end else if (flag_read && flag_reg) begin
            rd_seen_reg <= 1'b1;
        end
    end

    // Sticky flag; a new request wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            flag_reg <= `PODC_RST_FLAG;
        end else if (edge_hit || level_hit) begin
            flag_reg <= 1'b1;
        end else if (clear_ok) begin
            flag_reg <= 1'b0;
        end
    end

    assign flag = flag_reg;

    AST_EDGE_SETS: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        (!sampling && prev_reg && !pin_n) |=> flag_reg)
        else $error("falling edge did not set flag");
    AST_SIXTEEN_LOWS: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        (sampling && tick && !pin_n && count_reg == 5'h0F)
        |=> (flag_reg && count_reg == 5'h10))
        else $error("sixteenth low sample did not set flag");
    AST_HIGH_RESTARTS: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        (sampling && tick && pin_n) |=> (count_reg == 5'h00))
        else $error("high sample did not restart low run");
    AST_CLEAR_NEEDS_HIGH: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        (sampling && flag_reg && !high_seen_reg && !tick) |=> flag_reg)
        else $error("flag cleared before a high sample");
endmodule

// ### verif/podc_pins.sv
`timescale 1ns/1ps

// Far side of the block: fault sources and the complementary pair pins
module podc_pins #(
    parameter int N_IN   = 4,
    parameter int N_PAIR = 3
) (
    input  wire logic              clk,
    input  wire logic [N_IN:0]     lvl_n,
    input  wire logic [N_PAIR-1:0] want_p,
    input  wire logic [N_PAIR-1:0] want_n,
    input  wire logic              hiz,
    output logic      [N_IN-1:0]   fault_n,
    output logic                   ch0_n,
    output logic      [N_PAIR-1:0] pin_p,
    output logic      [N_PAIR-1:0] pin_n
);
    logic [N_PAIR-1:0] last_p_reg;
    logic [N_PAIR-1:0] last_n_reg;

    // Fault sources drive their lines hard, so no pull level is involved
    assign fault_n = lvl_n[N_IN-1:0];
    assign ch0_n   = lvl_n[N_IN];

    // Remember what the timer drove last, while it still drives
    always_ff @(posedge clk) begin
        if (!hiz) begin
            last_p_reg <= want_p;
            last_n_reg <= want_n;
        end
    end

    // Released pins float: show the inverse of the last level, so a stale
    // value never passes for live drive
    assign pin_p = hiz ? ~last_p_reg : want_p;
    assign pin_n = hiz ? ~last_n_reg : want_n;
endmodule

// ### verif/podc_top_tb.sv
`timescale 1ns/1ps

module podc_top_tb;
    localparam int NI = 4;
    localparam int NP = 3;
    logic            CORE_CLK;
    logic            RSTN;
    logic [NI:0]     lvl_n;
    logic [2*NI+1:0] mode;
    logic [NI:0]     frd;
    logic [NI:0]     fclr;
    logic [NI:0]     flag;
    logic            in_irq_en;
    logic            ch0_irq_en;
    logic [NP-1:0]   want_p;
    logic [NP-1:0]   want_n;
    logic [NP-1:0]   pin_p;
    logic [NP-1:0]   pin_n;
    logic [NI-1:0]   fault_n;
    logic            ch0_n;
    logic [NP-1:0]   func;
    logic            pol;
    logic            ord;
    logic            oclr;
    logic            oflag;
    logic            sw;
    logic            hz;
    logic            hz0;
    logic            irq_i;
    logic            irq_o;
    int              miscompares;
    int              checks_done;
    int              div;

    podc_top #(.N_IN(NI), .N_PAIR(NP)) dut (
        .CORE_CLK                       (CORE_CLK),
        .RSTN                           (RSTN),
        .FAULT_REQUEST_INPUT_N          (fault_n),
        .CHANNEL0_FAULT_REQUEST_INPUT_N (ch0_n),
        .INPUT_DETECT_MODE              (mode),
        .INPUT_FLAG_READ                (frd),
        .INPUT_FLAG_CLEAR               (fclr),
        .INPUT_REQUEST_FLAG             (flag),
        .INPUT_IRQ_EN                   (in_irq_en),
        .CH0_IRQ_EN                     (ch0_irq_en),
        .OUT_P                          (pin_p),
        .OUT_N                          (pin_n),
        .PIN_FUNC_OUTPUT                (func),
        .OUT_CMP_EN                     (3'h7),
        .ACTIVE_LEVEL_POLARITY_SELECT   (pol),
        .OUTPUT_LEVEL_SOURCE_SELECT     (1'b0),
        .PIN_LEVEL_SELECT               (6'h00),
        .OUT_FLAG_READ                  (ord),
        .OUT_FLAG_CLEAR                 (oclr),
        .OUTPUT_COMPARE_FLAG            (oflag),
        .OUT_IRQ_EN                     (in_irq_en),
        .SW_HIZ_REQ                     (sw),
        .HIZ_HIGH_CURRENT               (hz),
        .HIZ_CH0                        (hz0),
        .IRQ_INPUT                      (irq_i),
        .IRQ_OUTPUT                     (irq_o)
    );

    podc_pins #(.N_IN(NI), .N_PAIR(NP)) pins (
        .clk     (CORE_CLK),
        .lvl_n   (lvl_n),
        .want_p  (want_p),
        .want_n  (want_n),
        .hiz     (hz),
        .fault_n (fault_n),
        .ch0_n   (ch0_n),
        .pin_p   (pin_p),
        .pin_n   (pin_n)
    );

    // 40 MHz core clock
    always #12.5 CORE_CLK = ~CORE_CLK;

    task automatic step(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask

    task automatic chk(input string what, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic drive(input int i, input logic v);
        @(posedge CORE_CLK);
        lvl_n[i] <= v;
    endtask

    // Optional read pulse, then a write of 0; index NI+1 is the compare flag
    task automatic clr(input int i, input logic rd);
        @(posedge CORE_CLK);
        if (i > NI) ord <= rd;
        else frd[i] <= rd;
        @(posedge CORE_CLK);
        ord <= 1'b0;
        frd <= '0;
        if (i > NI) oclr <= 1'b1;
        else fclr[i] <= 1'b1;
        @(posedge CORE_CLK);
        oclr <= 1'b0;
        fclr <= '0;
        step(3);
    endtask

    // One cycle with both pins of pair 0 at the active level
    task automatic pulse_pair(input logic f);
        @(posedge CORE_CLK);
        func <= {NP{f}};
        want_p[0] <= pol;
        want_n[0] <= pol;
        @(posedge CORE_CLK);
        want_p <= {NP{~pol}};
        want_n <= {NP{~pol}};
        step(3);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial begin
        CORE_CLK = 1'b0;
        RSTN = 1'b0;
        {lvl_n, mode, frd, fclr, func, pol, ord, oclr, sw} = '1;
        {mode, frd, fclr, func, pol, ord, oclr, sw} = '0;
        {in_irq_en, ch0_irq_en} = 2'h3;
        want_p = {NP{1'b1}};
        want_n = {NP{1'b1}};
        miscompares = 0;
        checks_done = 0;
        step(2);
        chk("reset hiz", 1'b0, hz | hz0 | irq_i | irq_o | (|flag));
        @(posedge CORE_CLK);
        RSTN <= 1'b1;
        step(2);
        // Edge requests on every input, channel 0 included
        for (int i = 0; i <= NI; i++) begin
            drive(i, 1'b0);
            step(3);
            chk("edge flag", 1'b1, flag[i]);
            chk("hiz hc", 1'b1, hz);
            chk("hiz ch0", 1'b1, hz0);
            chk("irq in", 1'b1, irq_i);
            drive(i, 1'b1);
            clr(i, 1'b0);
            chk("clear unread", 1'b1, flag[i]);
            clr(i, 1'b1);
            chk("clear flag", 1'b0, flag[i]);
            chk("hiz off", 1'b0, hz | hz0 | irq_i);
        end
        $display("test edge done");
        // Low-level sampling at each divided rate on input 1
        for (int m = 1; m < 4; m++) begin
            div = (m == 3) ? 128 : 8 * m;
            @(posedge CORE_CLK);
            mode[3:2] <= m[1:0];
            if (m == 1) begin
                drive(1, 1'b0);
                step(80);
                drive(1, 1'b1);
                step(8);
            end
            drive(1, 1'b0);
            step(14 * div);
            chk("early flag", 1'b0, flag[1]);
            for (int k = 0; k < 2 * div + 4 && flag[1] !== 1'b1; k++)
                step(1);
            chk("sample flag", 1'b1, flag[1]);
            clr(1, 1'b1);
            chk("clear while low", 1'b1, flag[1]);
            drive(1, 1'b1);
            step(div + 2);
            clr(1, 1'b1);
            chk("clear after high", 1'b0, flag[1]);
        end
        $display("test sampling done");
        // Pair comparison for both polarities, first with pin function off
        for (int p = 0; p < 2; p++) begin
            @(posedge CORE_CLK);
            pol <= p[0];
            want_p <= {NP{~p[0]}};
            want_n <= {NP{~p[0]}};
            pulse_pair(1'b0);
            chk("cmp no func", 1'b0, oflag);
            pulse_pair(1'b1);
            chk("cmp flag", 1'b1, oflag);
            chk("cmp hiz", 1'b1, hz);
            chk("cmp ch0", 1'b0, hz0);
            chk("irq out", 1'b1, irq_o);
            @(posedge CORE_CLK);
            func <= '0;
            clr(NI + 1, 1'b0);
            chk("cmp unread", 1'b1, oflag);
            clr(NI + 1, 1'b1);
            chk("cmp clear", 1'b0, oflag | hz);
        end
        $display("test compare done");
        // Software force and release
        @(posedge CORE_CLK);
        sw <= 1'b1;
        step(2);
        chk("sw hiz hc", 1'b1, hz);
        chk("sw hiz ch0", 1'b1, hz0);
        @(posedge CORE_CLK);
        sw <= 1'b0;
        step(2);
        chk("sw release", 1'b0, hz | hz0);
        $display("test software done");
        // Enables off: both causes still force high-Z, no interrupt
        @(posedge CORE_CLK);
        {in_irq_en, ch0_irq_en} <= 2'h0;
        drive(0, 1'b0);
        pulse_pair(1'b1);
        chk("irq in off", 1'b0, irq_i);
        chk("irq out off", 1'b0, irq_o);
        chk("off hiz", 1'b1, hz & hz0);
        @(posedge CORE_CLK);
        func <= '0;
        lvl_n[0] <= 1'b1;
        clr(0, 1'b1);
        clr(NI + 1, 1'b1);
        chk("off clear", 1'b0, hz | hz0 | flag[0] | oflag);
        $display("test interrupt enable done");
        end_sim();
    end

    // Watchdog, well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        miscompares++;
        end_sim();
    end
endmodule
